/* dp_user_ports_pkg.sv */
package dp_user_ports_pkg;

	// audio word layout
	localparam int AUDIO_BITS = 32;
	localparam int SAMPLE_BITS = 24;
	localparam int CODE_BITS = 4;
	localparam int ID_FIELD_BITS = 4;
	localparam logic [3:0] PREAMBLE_BLOCK_START = 4'h1;
	localparam logic [3:0] PREAMBLE_SUBFRAME1 = 4'h2;
	localparam logic [3:0] PREAMBLE_SUBFRAME2 = 4'h3;

	// multi-stream video layout, streams 2 to 4
	localparam int MST_STREAMS = 3;
	localparam int PIXEL_LANES = 4;
	localparam int PIXEL_BITS = 48;
	localparam int RES_BITS = 16;

	// user pixel width codes: lanes in use per video clock
	localparam logic [1:0] WIDTH_ONE = 2'h0;
	localparam logic [1:0] WIDTH_TWO = 2'h1;
	localparam logic [1:0] WIDTH_FOUR = 2'h2;
	localparam logic [3:0] LANES_ONE = 4'h1;
	localparam logic [3:0] LANES_TWO = 4'h3;
	localparam logic [3:0] LANES_FOUR = 4'hF;

	typedef struct packed {
		logic                   parity;
		logic                   channel_status;
		logic                   user_bit;
		logic                   validity;
		logic [SAMPLE_BITS-1:0] sample;
		logic [CODE_BITS-1:0]   preamble_code;
	} audio_word_s;

	typedef struct packed {
		logic [ID_FIELD_BITS-1:0] packet_stream;
		logic [ID_FIELD_BITS-1:0] channel;
	} audio_id_s;

	typedef logic [PIXEL_LANES-1:0][PIXEL_BITS-1:0] pixel_lanes_t;

	typedef struct packed {
		logic         vsync;
		logic         hsync;
		logic         field_select;
		logic         enable;
		pixel_lanes_t pixel_lane;
	} video_s;

	typedef struct packed {
		logic [RES_BITS-1:0] horizontal_resolution;
		logic [RES_BITS-1:0] vertical_resolution;
	} resolution_s;

	localparam audio_word_s AUDIO_WORD_RESET = '0;
	localparam audio_id_s AUDIO_ID_RESET = '0;
	localparam video_s VIDEO_RESET = '0;
	localparam resolution_s RESOLUTION_RESET = '0;

endpackage

/* dp_user_ports.sv */
// Contract
// - low nibble holds the subframe preamble code
// - bits 27 to 4 hold sample
// - bits 28 to 31: validity, user, status, parity
// - id: channel low nibble, stream high nibble
// - source audio word taken on valid and ready
// - sink audio transfer on valid and ready
// - source pixel width set per stream
// - one sink pixel width for all streams
// - sink drives per-stream horizontal, vertical resolution
// - sink drives syncs, field, enable, four lanes
`timescale 1ns/10ps
`default_nettype none

module dp_user_ports #(
	parameter int STREAMS = dp_user_ports_pkg::MST_STREAMS,
	parameter int LANES   = dp_user_ports_pkg::PIXEL_LANES
) (
	input  wire logic                          clk_sys,           // 50 MHz
	input  wire logic                          reset,             // sync, high
	input  wire logic                          aud_reset,         // audio, high
	input  wire logic                          snk_aud_reset_n,   // sink aud, low
	// source audio ingress
	input  wire dp_user_ports_pkg::audio_word_s s_axis_tdata,     // word
	input  wire dp_user_ports_pkg::audio_id_s  s_axis_tid,        // id
	input  wire logic                          s_axis_tvalid,     // valid
	output logic                               s_axis_tready,     // ready
	output dp_user_ports_pkg::audio_word_s     src_aud_word,      // to core
	output dp_user_ports_pkg::audio_id_s       src_aud_id,        // to core
	output logic                               src_aud_valid,     // to core
	input  wire logic                          src_aud_ready,     // from core
	output logic                               src_preamble_error, // bad code
	// sink audio egress
	input  wire dp_user_ports_pkg::audio_word_s snk_aud_word,     // from core
	input  wire dp_user_ports_pkg::audio_id_s  snk_aud_id,        // from core
	input  wire logic                          snk_aud_valid,     // from core
	output logic                               snk_aud_ready,     // to core
	output dp_user_ports_pkg::audio_word_s     m_axis_tdata,      // word
	output dp_user_ports_pkg::audio_id_s       m_axis_tid,        // id
	output logic                               m_axis_tvalid,     // valid
	input  wire logic                          m_axis_tready,     // ready
	// source video streams 2 to 4, pins
	input  wire logic [STREAMS-1:0]            src_video_clock_n, // per stream
	input  wire logic [STREAMS-1:0]            src_video_reset_n, // high
	input  wire dp_user_ports_pkg::video_s     src_video_in [STREAMS], // pins
	input  wire logic [1:0]                    src_pixel_width [STREAMS], // w
	output dp_user_ports_pkg::video_s          src_video_out [STREAMS], // core
	output logic [STREAMS-1:0]                 src_video_strobe,  // new beat
	// sink video streams 2 to 4
	input  wire dp_user_ports_pkg::video_s     snk_video_in [STREAMS], // core
	input  wire logic [STREAMS-1:0]            snk_video_strobe,  // core beat
	input  wire dp_user_ports_pkg::resolution_s snk_msa_in [STREAMS], // core
	input  wire logic [1:0]                    snk_pixel_width,   // all
	output dp_user_ports_pkg::video_s          snk_video_out [STREAMS], // pins
	output dp_user_ports_pkg::resolution_s     snk_resolution [STREAMS] // pins
);

	if (STREAMS != dp_user_ports_pkg::MST_STREAMS)
	begin : g_stream_check
		$error("stream count must match the package");
	end
	if (LANES != dp_user_ports_pkg::PIXEL_LANES)
	begin : g_lane_check
		$error("lane count must match the package");
	end

	function automatic logic [3:0] lane_mask(input logic [1:0] width);
		case (width)
			dp_user_ports_pkg::WIDTH_ONE: lane_mask = dp_user_ports_pkg::LANES_ONE;
			dp_user_ports_pkg::WIDTH_TWO: lane_mask = dp_user_ports_pkg::LANES_TWO;
			default: lane_mask = dp_user_ports_pkg::LANES_FOUR;
		endcase
	endfunction

	function automatic dp_user_ports_pkg::video_s apply_width(
		input dp_user_ports_pkg::video_s v,
		input logic [1:0]                width
	);
		logic [3:0] m;
		m = lane_mask(width);
		apply_width = v;
		for (int l = 0; l < LANES; l++)
		begin
			if (!m[l])
				apply_width.pixel_lane[l] = '0;
		end
	endfunction

	function automatic logic code_known(input logic [3:0] code);
		code_known = (code == dp_user_ports_pkg::PREAMBLE_BLOCK_START) ||
			(code == dp_user_ports_pkg::PREAMBLE_SUBFRAME1) ||
			(code == dp_user_ports_pkg::PREAMBLE_SUBFRAME2);
	endfunction

	// audio resets: audio high reset, sink streaming low reset, synchronised
	logic [1:0] aud_rst_sync_reg;
	logic [1:0] aud_rst_sync_next;
	logic [1:0] snk_rstn_sync_reg;
	logic [1:0] snk_rstn_sync_next;
	logic       src_aud_rst;
	logic       snk_aud_rst;

	always_comb
	begin
		aud_rst_sync_next = {aud_rst_sync_reg[0], aud_reset};
		snk_rstn_sync_next = {snk_rstn_sync_reg[0], snk_aud_reset_n};
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			aud_rst_sync_reg <= 2'h3;
			snk_rstn_sync_reg <= 2'h0;
		end
		else
		begin
			aud_rst_sync_reg <= aud_rst_sync_next;
			snk_rstn_sync_reg <= snk_rstn_sync_next;
		end
	end

	assign src_aud_rst = reset | aud_rst_sync_reg[1];
	assign snk_aud_rst = reset | aud_rst_sync_reg[1] | ~snk_rstn_sync_reg[1];

	// source audio holding stage
	logic                          src_full_reg;
	logic                          src_full_next;
	dp_user_ports_pkg::audio_word_s src_word_reg;
	dp_user_ports_pkg::audio_word_s src_word_next;
	dp_user_ports_pkg::audio_id_s  src_id_reg;
	dp_user_ports_pkg::audio_id_s  src_id_next;
	logic                          src_err_reg;
	logic                          src_err_next;
	logic                          src_take;

	assign s_axis_tready = ~src_aud_rst & (~src_full_reg | src_aud_ready);
	assign src_take = s_axis_tvalid & s_axis_tready;

	always_comb
	begin
		src_full_next = src_full_reg;
		src_word_next = src_word_reg;
		src_id_next = src_id_reg;
		src_err_next = 1'b0;
		if (src_take)
		begin
			src_word_next = s_axis_tdata;
			src_id_next = s_axis_tid;
			src_full_next = 1'b1;
			src_err_next = ~code_known(s_axis_tdata.preamble_code);
		end
		else if (src_aud_ready)
			src_full_next = 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (src_aud_rst)
		begin
			src_full_reg <= 1'b0;
			src_word_reg <= dp_user_ports_pkg::AUDIO_WORD_RESET;
			src_id_reg <= dp_user_ports_pkg::AUDIO_ID_RESET;
			src_err_reg <= 1'b0;
		end
		else
		begin
			src_full_reg <= src_full_next;
			src_word_reg <= src_word_next;
			src_id_reg <= src_id_next;
			src_err_reg <= src_err_next;
		end
	end

	assign src_aud_valid = src_full_reg;
	assign src_aud_word = src_word_reg;
	assign src_aud_id = src_id_reg;
	assign src_preamble_error = src_err_reg;

	// sink audio output stage
	logic                          snk_full_reg;
	logic                          snk_full_next;
	dp_user_ports_pkg::audio_word_s snk_word_reg;
	dp_user_ports_pkg::audio_word_s snk_word_next;
	dp_user_ports_pkg::audio_id_s  snk_id_reg;
	dp_user_ports_pkg::audio_id_s  snk_id_next;

	assign snk_aud_ready = ~snk_aud_rst & (~snk_full_reg | m_axis_tready);

	always_comb
	begin
		snk_full_next = snk_full_reg;
		snk_word_next = snk_word_reg;
		snk_id_next = snk_id_reg;
		if (snk_aud_valid && snk_aud_ready)
		begin
			snk_word_next = snk_aud_word;
			snk_id_next = snk_aud_id;
			snk_full_next = 1'b1;
		end
		else if (m_axis_tready)
			snk_full_next = 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (snk_aud_rst)
		begin
			snk_full_reg <= 1'b0;
			snk_word_reg <= dp_user_ports_pkg::AUDIO_WORD_RESET;
			snk_id_reg <= dp_user_ports_pkg::AUDIO_ID_RESET;
		end
		else
		begin
			snk_full_reg <= snk_full_next;
			snk_word_reg <= snk_word_next;
			snk_id_reg <= snk_id_next;
		end
	end

	assign m_axis_tvalid = snk_full_reg;
	assign m_axis_tdata = snk_word_reg;
	assign m_axis_tid = snk_id_reg;

	// source video: pins synchronised, sampled on video clock rise
	logic [STREAMS-1:0]        vclk_meta_reg;
	logic [STREAMS-1:0]        vclk_sync_reg;
	logic [STREAMS-1:0]        vclk_prev_reg;
	logic [STREAMS-1:0]        vrst_meta_reg;
	logic [STREAMS-1:0]        vrst_sync_reg;
	dp_user_ports_pkg::video_s vin_meta_reg [STREAMS];
	dp_user_ports_pkg::video_s vin_sync_reg [STREAMS];
	dp_user_ports_pkg::video_s vout_reg [STREAMS];
	dp_user_ports_pkg::video_s vout_next [STREAMS];
	logic [STREAMS-1:0]        vstb_reg;
	logic [STREAMS-1:0]        vstb_next;

	always_comb
	begin
		for (int s = 0; s < STREAMS; s++)
		begin
			vout_next[s] = vout_reg[s];
			vstb_next[s] = 1'b0;
			if (vrst_sync_reg[s])
				vout_next[s] = dp_user_ports_pkg::VIDEO_RESET;
			else if (vclk_sync_reg[s] && !vclk_prev_reg[s])
			begin
				vout_next[s] = apply_width(vin_sync_reg[s], src_pixel_width[s]);
				vstb_next[s] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			vclk_meta_reg <= '0;
			vclk_sync_reg <= '0;
			vclk_prev_reg <= '0;
			vrst_meta_reg <= '1;
			vrst_sync_reg <= '1;
			vstb_reg <= '0;
			for (int s = 0; s < STREAMS; s++)
			begin
				vin_meta_reg[s] <= dp_user_ports_pkg::VIDEO_RESET;
				vin_sync_reg[s] <= dp_user_ports_pkg::VIDEO_RESET;
				vout_reg[s] <= dp_user_ports_pkg::VIDEO_RESET;
			end
		end
		else
		begin
			vclk_meta_reg <= src_video_clock_n;
			vclk_sync_reg <= vclk_meta_reg;
			vclk_prev_reg <= vclk_sync_reg;
			vrst_meta_reg <= src_video_reset_n;
			vrst_sync_reg <= vrst_meta_reg;
			vstb_reg <= vstb_next;
			for (int s = 0; s < STREAMS; s++)
			begin
				vin_meta_reg[s] <= src_video_in[s];
				vin_sync_reg[s] <= vin_meta_reg[s];
				vout_reg[s] <= vout_next[s];
			end
		end
	end

	assign src_video_out = vout_reg;
	assign src_video_strobe = vstb_reg;

	// sink video outputs and resolutions
	dp_user_ports_pkg::video_s      svid_reg [STREAMS];
	dp_user_ports_pkg::video_s      svid_next [STREAMS];
	dp_user_ports_pkg::resolution_s sres_reg [STREAMS];
	dp_user_ports_pkg::resolution_s sres_next [STREAMS];

	always_comb
	begin
		for (int s = 0; s < STREAMS; s++)
		begin
			svid_next[s] = svid_reg[s];
			sres_next[s] = snk_msa_in[s];
			if (snk_video_strobe[s])
			begin
				svid_next[s] = apply_width(snk_video_in[s], snk_pixel_width);
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		for (int s = 0; s < STREAMS; s++)
		begin
			if (reset)
			begin
				svid_reg[s] <= dp_user_ports_pkg::VIDEO_RESET;
				sres_reg[s] <= dp_user_ports_pkg::RESOLUTION_RESET;
			end
			else
			begin
				svid_reg[s] <= svid_next[s];
				sres_reg[s] <= sres_next[s];
			end
		end
	end

	assign snk_video_out = svid_reg;
	assign snk_resolution = sres_reg;

endmodule

`default_nettype wire

/* dp_user_ports_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module dp_user_ports_assertions #(
	parameter int STREAMS = 3
) (
	input wire logic                               clk_sys,            // clock
	input wire logic                               reset,              // high
	input wire dp_user_ports_pkg::audio_word_s     s_axis_tdata,       // in
	input wire logic                               s_axis_tvalid,      // in
	input wire logic                               s_axis_tready,      // out
	input wire dp_user_ports_pkg::audio_word_s     src_aud_word,       // out
	input wire logic                               src_aud_valid,      // out
	input wire logic                               src_aud_ready,      // in
	input wire logic                               src_preamble_error, // out
	input wire dp_user_ports_pkg::audio_word_s     snk_aud_word,       // in
	input wire logic                               snk_aud_valid,      // in
	input wire logic                               snk_aud_ready,      // out
	input wire dp_user_ports_pkg::audio_word_s     m_axis_tdata,       // out
	input wire logic                               m_axis_tvalid,      // out
	input wire logic                               m_axis_tready,      // in
	input wire dp_user_ports_pkg::resolution_s     snk_msa_in [STREAMS], // in
	input wire dp_user_ports_pkg::resolution_s     snk_resolution [STREAMS] // out
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_src_take: assert property (
		s_axis_tvalid && s_axis_tready |=>
		src_aud_valid && src_aud_word == $past(s_axis_tdata))
		else $error("source word not passed on");
	a_src_hold: assert property (
		src_aud_valid && !src_aud_ready |=> src_aud_valid && $stable(src_aud_word))
		else $error("source word dropped while stalled");
	a_src_refuse: assert property (
		src_aud_valid && !src_aud_ready |-> !s_axis_tready)
		else $error("source ready while full");
	a_preamble_flag: assert property (
		s_axis_tvalid && s_axis_tready |=> src_preamble_error ==
		!($past(s_axis_tdata.preamble_code) inside {4'h1, 4'h2, 4'h3}))
		else $error("preamble flag wrong");
	a_snk_take: assert property (
		snk_aud_valid && snk_aud_ready |=>
		m_axis_tvalid && m_axis_tdata == $past(snk_aud_word))
		else $error("sink word not passed on");
	a_snk_hold: assert property (
		m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid && $stable(m_axis_tdata))
		else $error("sink word dropped while stalled");
	a_snk_refuse: assert property (
		m_axis_tvalid && !m_axis_tready |-> !snk_aud_ready)
		else $error("sink ready while full");
	a_res_copy: assert property (
		!$past(reset) |-> snk_resolution[0] == $past(snk_msa_in[0]))
		else $error("resolution not copied");
endmodule
bind dp_user_ports dp_user_ports_assertions #(.STREAMS(STREAMS)) chk (
	.clk_sys, .reset, .s_axis_tdata, .s_axis_tvalid, .s_axis_tready,
	.src_aud_word, .src_aud_valid, .src_aud_ready, .src_preamble_error,
	.snk_aud_word, .snk_aud_valid, .snk_aud_ready, .m_axis_tdata,
	.m_axis_tvalid, .m_axis_tready, .snk_msa_in, .snk_resolution);
`default_nettype wire

/* dp_audio_listener.sv */
`timescale 1ns/10ps
`default_nettype none
module dp_audio_listener (
	input wire logic clk_sys,       // clock
	input wire logic slow,          // stall three cycles in four
	output logic     m_axis_tready  // ready toward sink output
);
	logic [1:0] cnt_reg = 2'h0;
	always_ff @(posedge clk_sys)
	begin
		cnt_reg <= cnt_reg + 2'h1;
		m_axis_tready <= !slow || cnt_reg == 2'h0;
	end
endmodule
`default_nettype wire

/* dp_user_ports_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module dp_user_ports_bench;
	localparam int NS = dp_user_ports_pkg::MST_STREAMS;
	logic clk_sys = 1'b0;
	logic reset, aud_reset, snk_aud_reset_n, slow, s_axis_tvalid, s_axis_tready;
	logic src_aud_valid, src_aud_ready, src_preamble_error, snk_aud_valid;
	logic snk_aud_ready, m_axis_tvalid, m_axis_tready;
	logic [1:0] snk_pixel_width;
	logic [1:0] src_pixel_width [NS];
	logic [NS-1:0] src_video_clock_n, src_video_reset_n, src_video_strobe;
	logic [NS-1:0] snk_video_strobe;
	logic [NS-1:0] pend = '0;
	dp_user_ports_pkg::audio_word_s s_axis_tdata, src_aud_word, snk_aud_word;
	dp_user_ports_pkg::audio_word_s m_axis_tdata;
	dp_user_ports_pkg::audio_id_s s_axis_tid, src_aud_id, snk_aud_id, m_axis_tid;
	dp_user_ports_pkg::video_s src_video_in [NS], src_video_out [NS];
	dp_user_ports_pkg::video_s snk_video_in [NS], snk_video_out [NS];
	dp_user_ports_pkg::resolution_s snk_msa_in [NS], snk_resolution [NS];
	logic [199:0] qa[$], qm[$], qs[NS][$], qk[NS][$];
	int fail_count = 0;
	int check_count = 0;

	dp_user_ports #(.STREAMS(NS)) dut (
		.clk_sys, .reset, .aud_reset, .snk_aud_reset_n, .s_axis_tdata,
		.s_axis_tid, .s_axis_tvalid, .s_axis_tready, .src_aud_word, .src_aud_id,
		.src_aud_valid, .src_aud_ready, .src_preamble_error, .snk_aud_word,
		.snk_aud_id, .snk_aud_valid, .snk_aud_ready, .m_axis_tdata, .m_axis_tid,
		.m_axis_tvalid, .m_axis_tready, .src_video_clock_n, .src_video_reset_n,
		.src_video_in, .src_pixel_width, .src_video_out, .src_video_strobe,
		.snk_video_in, .snk_video_strobe, .snk_msa_in, .snk_pixel_width,
		.snk_video_out, .snk_resolution);
	dp_audio_listener partner (.clk_sys, .slow, .m_axis_tready);

	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		src_aud_ready <= 1'($urandom) || !slow;

	task results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(string what, logic [199:0] exp, logic [199:0] got);
		check_count++;
		if (exp !== got)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_hi(bit snk);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while ((snk ? snk_aud_ready : s_axis_tready) !== 1'b1 && n < 99);
		if ((snk ? snk_aud_ready : s_axis_tready) !== 1'b1)
		begin
			check("handshake wait", 1, 0);
			results;
		end
	endtask

	function automatic dp_user_ports_pkg::video_s rnd_video();
		logic [223:0] r;
		r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		return r[195:0];
	endfunction

	// unused lanes read as zero
	function automatic dp_user_ports_pkg::video_s masked(
		dp_user_ports_pkg::video_s v, logic [1:0] w);
		if (w == dp_user_ports_pkg::WIDTH_ONE)
			v.pixel_lane[3:1] = '0;
		if (w == dp_user_ports_pkg::WIDTH_TWO)
			v.pixel_lane[3:2] = '0;
		return v;
	endfunction

	task automatic audio(int cnt, bit snk);
		dp_user_ports_pkg::audio_word_s w;
		dp_user_ports_pkg::audio_id_s d;
		for (int k = 0; k < cnt; k++)
		begin
			w = $urandom;
			w.preamble_code = 4'(k % 3 + 1);
			d = 8'($urandom);
			if (snk)
			begin
				snk_aud_word <= w;
				snk_aud_id <= d;
				snk_aud_valid <= 1'b1;
				qm.push_back({d, w});
				wait_hi(1'b1);
			end
			else
			begin
				s_axis_tdata <= w;
				s_axis_tid <= d;
				s_axis_tvalid <= 1'b1;
				qa.push_back({d, w});
				wait_hi(1'b0);
			end
		end
		snk_aud_valid <= 1'b0;
		s_axis_tvalid <= 1'b0;
		@(posedge clk_sys);
		$display("audio test done");
	endtask

	task automatic video(int beats, bit snk);
		dp_user_ports_pkg::video_s v;
		for (int b = 0; b < beats; b++)
		begin
			snk_pixel_width <= 2'(b);
			for (int i = 0; i < NS; i++)
			begin
				v = rnd_video();
				src_pixel_width[i] <= 2'(b + i);
				src_video_in[i] <= v;
				snk_video_in[i] <= v;
				snk_msa_in[i] <= $urandom;
				if (snk)
					qk[i].push_back(masked(v, 2'(b)));
				else
					qs[i].push_back(masked(v, 2'(b + i)));
			end
			repeat (4) @(posedge clk_sys);
			src_video_clock_n <= {NS{!snk}};
			snk_video_strobe <= {NS{snk}};
			@(posedge clk_sys);
			snk_video_strobe <= '0;
			repeat (9) @(posedge clk_sys);
			src_video_clock_n <= '0;
			repeat (6) @(posedge clk_sys);
		end
		$display("video test done");
	endtask

	always @(negedge clk_sys)
	begin
		if (src_preamble_error !== 1'b0)
			check("preamble error", 0, 1);
		if (src_aud_valid && src_aud_ready)
			check("src audio", qa.pop_front(), {src_aud_id, src_aud_word});
		if (m_axis_tvalid && m_axis_tready)
			check("snk audio", qm.pop_front(), {m_axis_tid, m_axis_tdata});
		for (int i = 0; i < NS; i++)
		begin
			if (src_video_strobe[i])
				check("src video", qs[i].pop_front(), src_video_out[i]);
			if (pend[i])
			begin
				check("snk video", qk[i].pop_front(), snk_video_out[i]);
				check("snk res", snk_msa_in[i], snk_resolution[i]);
			end
			pend[i] = snk_video_strobe[i];
		end
	end

	initial
	begin
		void'($urandom(32'h6DFA6EA4));
		{reset, aud_reset, snk_aud_reset_n, slow} = 4'hE;
		{s_axis_tvalid, snk_aud_valid, snk_pixel_width} = '0;
		{s_axis_tdata, s_axis_tid, snk_aud_word, snk_aud_id} = '0;
		src_video_clock_n = '0;
		snk_video_strobe = '0;
		src_video_reset_n = '1;
		src_video_in = '{default: '0};
		snk_video_in = '{default: '0};
		snk_msa_in = '{default: '0};
		src_pixel_width = '{default: 2'h0};
		repeat (3) @(posedge clk_sys);
		{reset, aud_reset, snk_aud_reset_n} <= 3'h1;
		src_video_reset_n <= '0;
		repeat (4) @(posedge clk_sys);
		audio(12, 1'b0);
		audio(12, 1'b1);
		slow <= 1'b1;
		audio(12, 1'b0);
		audio(12, 1'b1);
		video(4, 1'b0);
		src_video_reset_n <= '1;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		for (int i = 0; i < NS; i++)
			check("src reset", 0, src_video_out[i]);
		@(posedge clk_sys);
		src_video_reset_n <= '0;
		video(4, 1'b1);
		repeat (20) @(posedge clk_sys);
		aud_reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		check("aud reset", 0, {s_axis_tready, snk_aud_ready});
		@(posedge clk_sys);
		aud_reset <= 1'b0;
		snk_aud_reset_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		check("snk reset", 2'h2, {s_axis_tready, snk_aud_ready});
		@(posedge clk_sys);
		snk_aud_reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		$display("reset test done");
		check("words left", 0, qa.size() + qm.size());
		results;
	end
endmodule
`default_nettype wire
